// ---- tb/smcg_core_model.sv ----
/*
 * Far-side model: the TAP status source and the data out pin with its pull-up.
 * Assumes the controller's core_clk and rst; the bench seeds the generator.
 */
`timescale 1ns/10ps

module smcg_core_model
(
    input wire logic core_clk,
    input wire logic rst,
    output logic tap_shifting,
    output logic tap_tdo_data,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    output wire logic tdo_pin
);
    initial tap_tdo_data = 1'b0;
    // Nobody drives the pin outside shifts, so the board pull-up wins.
    assign tdo_pin = tdo_oe ? tdo_o : 1'b1;
    // Shift bursts come at random; data flips each cycle so stale data shows.
    always @(posedge core_clk)
    begin
        tap_shifting <= rst ? 1'b0 : 1'($urandom_range(1));
        tap_tdo_data <= ~tap_tdo_data;
    end
endmodule

// ---- tb/tb.sv ----
/*
 * Bench of the sleep controller: bus tasks, sleep and wake runs, queued checks.
 * Assumes the far-side model drives the TAP status inputs.
 */
`timescale 1ns/10ps

module tb;
    logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, sleep_exec = 0, adc_conv_start = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic hreadyout, hresp, crystal_clock_sel = 1, brownout_fuse_enable = 0;
    logic debug_fuse_enable = 0, scan_port_fuse_enable = 0, ext_irq_first = 0;
    logic ext_irq_second = 0, ext_irq_third = 0, tap_shifting, tap_tdo_data;
    logic tdo_o, tdo_oe, tdo_pin, core_halt, scan_port_en, adc_extended_conv, async_regs_valid;
    smcg_pkg::smcg_wake_t wake_src = '0;
    smcg_pkg::smcg_clk_t clk_en;
    smcg_pkg::smcg_ana_t ana_en;
    logic [63:0] q[$];
    logic [63:0] e;
    logic rd_dp = 0, st_chk = 0;
    logic [2:0] pq = 3'h7;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    localparam logic [15:0] WDLY = 16'h0008;

    always #5 core_clk = ~core_clk;

    smcg_sleep_ctrl smcg_sleep_ctrl_i (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sleep_exec,
        .crystal_clock_sel, .brownout_fuse_enable, .debug_fuse_enable, .scan_port_fuse_enable,
        .adc_conv_start, .ext_irq_first, .ext_irq_second, .ext_irq_third, .wake_src,
        .tap_shifting, .tap_tdo_data, .tdo_o, .tdo_oe, .clk_en, .ana_en, .core_halt,
        .scan_port_en, .adc_extended_conv, .async_regs_valid);
    smcg_core_model smcg_core_model_i (.core_clk, .rst, .tap_shifting, .tap_tdo_data,
        .tdo_o, .tdo_oe, .tdo_pin);

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Oldest note is compared when a read data phase ends or a status look is due.
    always @(posedge core_clk)
    begin
        cyc++;
        if (rd_dp || st_chk)
        begin
            e = q.pop_front();
            check(rd_dp ? "hrdata" : "outputs", (rd_dp ? hrdata : {hresp, 14'h0, clk_en, ana_en,
                core_halt, scan_port_en, adc_extended_conv, async_regs_valid}) & e[63:32],
                e[31:0]);
        end
        // Data out follows the TAP data one cycle late; a pin not shifting must read high.
        if (!pq[0])
            check("tdo", {tdo_o, tdo_pin | pq[2]}, {pq[1], 1'b1});
        pq <= {tap_shifting, tap_tdo_data, rst};
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // One single word transfer; a read notes its expected data first.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w)
            q.push_back({32'hffffffff, d});
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= smcg_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= smcg_pkg::HSIZE_WORD;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h0;
        rd_dp <= !w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic expect_st(input logic [16:0] m, input logic [16:0] x);
        q.push_back({1'b1, 14'h0, m, 15'h0, x});
        st_chk <= 1'b1;
        @(posedge core_clk);
        st_chk <= 1'b0;
    endtask

    function automatic logic [6:0] exp_clk(input logic [2:0] m, input logic a, input logic d);
        case (m)
            3'h0: return {4'h3, 2'h3, a};
            3'h1: return {4'h1, 2'h3, a};
            3'h2: return {5'h00, d, 1'b0};
            3'h3: return {4'h0, a, d, a};
            3'h6: return 7'h02;
            3'h7: return {4'h0, a, 1'b1, a};
            default: return 7'h7f;
        endcase
    endfunction

    // Enter one mode with random settings, try a refused wake outside idle, then wake and time it.
    task automatic sleep_run(input logic [2:0] m);
        logic [11:0] c;
        logic dp;
        logic lg;
        int n;
        c = 12'($urandom);
        c[11:10] = 2'h0;
        c[3:0] = {1'b0, m};
        dp = m > 3'h1;
        lg = m < 3'h4 || (m > 3'h5 && crystal_clock_sel);
        bus(1'b1, smcg_pkg::OFS_CTRL, {20'h0, c});
        sleep_exec <= 1'b1;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        if (!lg)
            expect_st(17'h1fc08, 17'h1fc00);
        else
        begin
            expect_st(17'h1fffc, {exp_clk(m, c[4], debug_fuse_enable), c[6], c[7] & !dp,
                brownout_fuse_enable | c[6] | (c[7] & c[8]), brownout_fuse_enable, c[9], !dp,
                1'b1, scan_port_fuse_enable & !c[5], 2'h0});
            if (m != 3'h0)
            begin
                ext_irq_first <= 1'b1;
                repeat (8) @(posedge core_clk);
                expect_st(17'h00008, 17'h00008);
                ext_irq_first <= 1'b0;
            end
            wake_src.two_wire_match <= 1'b1;
            n = 0;
            do begin @(posedge core_clk); n++; end while (core_halt !== 1'b0 && n < 3000);
            wake_src.two_wire_match <= 1'b0;
            check("wake", n, !dp ? 3 : (m > 3'h5 || debug_fuse_enable) ? 8 : WDLY + 2);
            expect_st(17'h1fc09, {7'h7f, 6'h0, 3'h0, !(m == 3'h3 && !c[4])});
            bus(1'b1, smcg_pkg::OFS_STATUS, 32'h4);
        end
    endtask

    initial
    begin
        void'($urandom(30));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, smcg_pkg::OFS_CTRL, 32'h0);
        bus(1'b0, smcg_pkg::OFS_WAKE_DLY, {16'h0, smcg_pkg::WAKE_DLY_RESET});
        bus(1'b0, 8'h0c, 32'h0);
        bus(1'b0, smcg_pkg::OFS_STATUS, 32'h8);
        bus(1'b1, smcg_pkg::OFS_WAKE_DLY, {16'h0, WDLY});
        bus(1'b1, smcg_pkg::OFS_WAKE_DLY, 32'h0);
        bus(1'b0, smcg_pkg::OFS_WAKE_DLY, {16'h0, WDLY});
        for (int p = 0; p < 2; p++)
        begin
            crystal_clock_sel <= p == 0;
            {debug_fuse_enable, brownout_fuse_enable, scan_port_fuse_enable} <= {3{p == 1}};
            for (int m = 0; m < 8; m++)
                sleep_run(3'(m));
        end
        // Converter on, start, then off and on again makes the next one extended.
        bus(1'b1, smcg_pkg::OFS_CTRL, 32'h40);
        @(posedge core_clk);
        adc_conv_start <= 1'b1;
        @(posedge core_clk);
        adc_conv_start <= 1'b0;
        @(posedge core_clk);
        expect_st(17'h00002, 17'h00000);
        bus(1'b1, smcg_pkg::OFS_CTRL, 32'h0);
        bus(1'b1, smcg_pkg::OFS_CTRL, 32'h40);
        @(posedge core_clk);
        expect_st(17'h00002, 17'h00002);
        @(posedge core_clk);
        end_of_test();
    end
endmodule

// ---- verilog/smcg_pkg.sv ----
/*
 * Package of the sleep-mode clock-gating controller: register map, field
 * positions, reset values, mode codes, wake-up timing and carrier structs.
 * Assumes a single 100 MHz core clock and an AHB-Lite register bus.
 */
package smcg_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_WAKE_DLY = 8'h08;

    // Control register field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_T2_ASYNC = 4;
    localparam int CTRL_SCAN_DIS = 5;
    localparam int CTRL_ADC_EN = 6;
    localparam int CTRL_CMP_EN = 7;
    localparam int CTRL_CMP_REF = 8;
    localparam int CTRL_WDT_EN = 9;
    localparam int CTRL_IRQ1_LVL = 10;
    localparam int CTRL_IRQ2_LVL = 11;
    localparam int CTRL_WIDTH = 12;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 12'h000;

    // Status register field positions.
    localparam int STAT_ASLEEP = 0;
    localparam int STAT_WAKING = 1;
    localparam int STAT_ASYNC_LOST = 2;
    localparam int STAT_ADC_EXT = 3;
    localparam int STAT_VREF_RDY = 4;
    localparam int STAT_MODE_LSB = 8;

    // Sleep mode codes.
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADC_NR = 3'h1;
    localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
    localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;
    localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

    // Wake-up timing, in core clock cycles.
    localparam logic [15:0] WAKE_OSC_RUN_CYC = 16'h0006;
    localparam logic [15:0] WAKE_IDLE_CYC = 16'h0001;
    localparam logic [15:0] WAKE_DLY_RESET = 16'h0400;
    localparam logic [15:0] VREF_START_CYC = 16'h0064;

    // AHB-Lite transfer type and size codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Clock domain and oscillator enables.
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } smcg_clk_t;

    localparam smcg_clk_t CLK_ALL_ON = 7'h7f;

    // Analog and housekeeping enables.
    typedef struct packed {
        logic adc;
        logic comparator;
        logic vref;
        logic brownout;
        logic watchdog;
        logic input_buf;
    } smcg_ana_t;

    localparam smcg_ana_t ANA_RESET = 6'h01;

    // Wake-up event sources, all on the core clock except the pins.
    typedef struct packed {
        logic two_wire_match;
        logic timer2;
        logic spm_ready;
        logic adc_done;
        logic other_io;
    } smcg_wake_t;

endpackage

// ---- verilog/smcg_sleep_ctrl.sv ----
/*
 * Sleep-mode controller: gates the clock domains and oscillators per sleep
 * mode code, filters wake-up sources, times the wake-up, drives the analog
 * side enables and the scan port output enable, behind an AHB-Lite slave.
 * Assumes the sleep request, wake events and TAP status come from logic on
 * core_clk; the external interrupt pins are asynchronous and synchronised.
 */
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps

module smcg_sleep_ctrl
(
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core and fuses.
    input wire logic sleep_exec,
    input wire logic crystal_clock_sel,
    input wire logic brownout_fuse_enable,
    input wire logic debug_fuse_enable,
    input wire logic scan_port_fuse_enable,
    input wire logic adc_conv_start,
    // Wake-up sources.
    input wire logic ext_irq_first,
    input wire logic ext_irq_second,
    input wire logic ext_irq_third,
    input wire smcg_pkg::smcg_wake_t wake_src,
    // Scan port data out.
    input wire logic tap_shifting,
    input wire logic tap_tdo_data,
    output logic tdo_o,
    output logic tdo_oe,
    // Gating and enables.
    output smcg_pkg::smcg_clk_t clk_en,
    output smcg_pkg::smcg_ana_t ana_en,
    output logic core_halt,
    output logic scan_port_en,
    output logic adc_extended_conv,
    output logic async_regs_valid
);

    typedef enum logic [2:0]
    {
        SMCG_ACTIVE = 3'b001,
        SMCG_SLEEP = 3'b010,
        SMCG_WAKE = 3'b100
    } smcg_state_t;

    smcg_state_t state_ff;
    smcg_state_t nxt_state;
    logic [smcg_pkg::CTRL_WIDTH-1:0] ctrl_ff;
    logic [15:0] wake_dly_ff;
    logic [2:0] mode_ff;
    logic [15:0] wake_cnt_ff;
    logic [2:0] irq_meta_ff;
    logic [2:0] irq_sync_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic adc_prev_ff;
    logic [15:0] vref_cnt_ff;
    logic wake_hit;
    logic sleep_ok;
    logic [15:0] wake_len;
    smcg_pkg::smcg_clk_t nxt_clk;
    smcg_pkg::smcg_ana_t nxt_ana;
    logic addr_ok;

    // Effective mode for a code: only legal if not reserved and, for the two
    // standby codes, only with a crystal clock option.
    function automatic logic mode_legal(input logic [2:0] code, input logic xtal);
        case (code)
            smcg_pkg::MODE_IDLE, smcg_pkg::MODE_ADC_NR, smcg_pkg::MODE_PWR_DOWN,
            smcg_pkg::MODE_PWR_SAVE: mode_legal = 1'b1;
            smcg_pkg::MODE_STANDBY, smcg_pkg::MODE_EXT_STANDBY: mode_legal = xtal;
            default: mode_legal = 1'b0;
        endcase
    endfunction

    // Clock domains and oscillators left running in a sleep mode.
    function automatic smcg_pkg::smcg_clk_t mode_clocks(input logic [2:0] code,
        input logic as2, input logic dbg);
        smcg_pkg::smcg_clk_t c;
        c = '0;
        case (code)
            smcg_pkg::MODE_IDLE:
            begin
                c.io = 1'b1;
                c.adc = 1'b1;
                c.asy = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = as2;
            end
            smcg_pkg::MODE_ADC_NR:
            begin
                c.adc = 1'b1;
                c.asy = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = as2;
            end
            smcg_pkg::MODE_PWR_DOWN: c.main_osc = dbg;
            smcg_pkg::MODE_PWR_SAVE:
            begin
                c.asy = as2;
                c.timer_osc = as2;
                c.main_osc = dbg;
            end
            smcg_pkg::MODE_STANDBY: c.main_osc = 1'b1;
            smcg_pkg::MODE_EXT_STANDBY:
            begin
                c.asy = as2;
                c.timer_osc = as2;
                c.main_osc = 1'b1;
            end
            default: c = smcg_pkg::CLK_ALL_ON;
        endcase
        return c;
    endfunction

    // Pin synchroniser for the three external interrupt requests.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_meta_ff <= 3'h0;
            irq_sync_ff <= 3'h0;
        end
        else
        begin
            irq_meta_ff <= {ext_irq_third, ext_irq_second, ext_irq_first};
            irq_sync_ff <= irq_meta_ff;
        end
    end

    // Wake filter for the mode being slept in. Edge-mode first and second
    // interrupts need the io clock, so only idle lets them through.
    always_comb
    begin
        logic ext_ok;
        logic t2_ok;
        ext_ok = irq_sync_ff[2]
            | (irq_sync_ff[1] & ctrl_ff[smcg_pkg::CTRL_IRQ2_LVL])
            | (irq_sync_ff[0] & ctrl_ff[smcg_pkg::CTRL_IRQ1_LVL]);
        t2_ok = wake_src.timer2 & ctrl_ff[smcg_pkg::CTRL_T2_ASYNC];
        case (mode_ff)
            smcg_pkg::MODE_IDLE: wake_hit = (|irq_sync_ff) | (|wake_src);
            smcg_pkg::MODE_ADC_NR: wake_hit = ext_ok | wake_src.two_wire_match
                | wake_src.timer2 | wake_src.spm_ready | wake_src.adc_done;
            smcg_pkg::MODE_PWR_SAVE, smcg_pkg::MODE_EXT_STANDBY:
                wake_hit = ext_ok | wake_src.two_wire_match | t2_ok;
            default: wake_hit = ext_ok | wake_src.two_wire_match;
        endcase
    end

    // Wake delay for the mode: idle and ADC noise reduction restart in one cycle, other
    // oscillator-running modes in six, stopped-oscillator modes wait the programmable start-up period.
    always_comb
    begin
        case (mode_ff)
            smcg_pkg::MODE_IDLE, smcg_pkg::MODE_ADC_NR: wake_len = smcg_pkg::WAKE_IDLE_CYC;
            smcg_pkg::MODE_STANDBY, smcg_pkg::MODE_EXT_STANDBY:
                wake_len = smcg_pkg::WAKE_OSC_RUN_CYC;
            default: wake_len = clk_en.main_osc ? smcg_pkg::WAKE_OSC_RUN_CYC : wake_dly_ff;
        endcase
    end

    assign sleep_ok = sleep_exec
        & mode_legal(ctrl_ff[smcg_pkg::CTRL_MODE_LSB +: 3], crystal_clock_sel);

    // Sleep sequencer.
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SMCG_ACTIVE: if (sleep_ok) nxt_state = SMCG_SLEEP;
            SMCG_SLEEP: if (wake_hit) nxt_state = SMCG_WAKE;
            SMCG_WAKE: if (wake_cnt_ff == 16'h0001) nxt_state = SMCG_ACTIVE;
            default: nxt_state = SMCG_ACTIVE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= SMCG_ACTIVE;
            mode_ff <= smcg_pkg::MODE_IDLE;
            wake_cnt_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == SMCG_ACTIVE && sleep_ok)
            begin
                mode_ff <= ctrl_ff[smcg_pkg::CTRL_MODE_LSB +: 3];
            end
            if (state_ff == SMCG_SLEEP && wake_hit)
            begin
                wake_cnt_ff <= wake_len;
            end
            else if (wake_cnt_ff != 16'h0000)
            begin
                wake_cnt_ff <= wake_cnt_ff - 16'h0001;
            end
        end
    end

    // Clock gates follow the sleep state. During the wake delay the
    // oscillator restarts but the domains stay gated until it is stable.
    always_comb
    begin
        nxt_clk = smcg_pkg::CLK_ALL_ON;
        if (nxt_state == SMCG_SLEEP)
        begin
            nxt_clk = mode_clocks(mode_ff, ctrl_ff[smcg_pkg::CTRL_T2_ASYNC], debug_fuse_enable);
        end
        else if (nxt_state == SMCG_WAKE)
        begin
            nxt_clk = clk_en;
            nxt_clk.main_osc = 1'b1;
        end
        if (state_ff == SMCG_ACTIVE && sleep_ok)
        begin
            nxt_clk = mode_clocks(ctrl_ff[smcg_pkg::CTRL_MODE_LSB +: 3],
                ctrl_ff[smcg_pkg::CTRL_T2_ASYNC], debug_fuse_enable);
        end
    end

    // Analog and housekeeping enables.
    always_comb
    begin
        logic deep;
        deep = (nxt_state != SMCG_ACTIVE) && !(nxt_clk.io || nxt_clk.adc);
        nxt_ana.adc = ctrl_ff[smcg_pkg::CTRL_ADC_EN];
        nxt_ana.comparator = ctrl_ff[smcg_pkg::CTRL_CMP_EN] & !deep;
        nxt_ana.brownout = brownout_fuse_enable;
        nxt_ana.watchdog = ctrl_ff[smcg_pkg::CTRL_WDT_EN];
        nxt_ana.vref = brownout_fuse_enable | ctrl_ff[smcg_pkg::CTRL_ADC_EN]
            | (ctrl_ff[smcg_pkg::CTRL_CMP_EN] & ctrl_ff[smcg_pkg::CTRL_CMP_REF]);
        nxt_ana.input_buf = !deep;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_en <= smcg_pkg::CLK_ALL_ON;
            ana_en <= smcg_pkg::ANA_RESET;
            core_halt <= 1'b0;
        end
        else
        begin
            clk_en <= nxt_clk;
            ana_en <= nxt_ana;
            core_halt <= (nxt_state != SMCG_ACTIVE);
        end
    end

    // Reference start-up: a reference that stays on stays ready; one that
    // was off must count its start-up time again before use.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            vref_cnt_ff <= 16'h0000;
        end
        else if (!ana_en.vref)
        begin
            vref_cnt_ff <= 16'h0000;
        end
        else if (vref_cnt_ff != smcg_pkg::VREF_START_CYC)
        begin
            vref_cnt_ff <= vref_cnt_ff + 16'h0001;
        end
    end

    // Converter restart tracking; a new restart wins over a conversion start.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            adc_prev_ff <= 1'b0;
            adc_extended_conv <= 1'b1;
        end
        else
        begin
            adc_prev_ff <= ctrl_ff[smcg_pkg::CTRL_ADC_EN];
            if (ctrl_ff[smcg_pkg::CTRL_ADC_EN] && !adc_prev_ff)
            begin
                adc_extended_conv <= 1'b1;
            end
            else if (adc_conv_start)
            begin
                adc_extended_conv <= 1'b0;
            end
        end
    end

    // Async timer contents are lost after a power-save sleep with timer2 on
    // the synchronous clock; software clears the flag by writing a one.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            async_regs_valid <= 1'b1;
        end
        else if (state_ff == SMCG_WAKE && nxt_state == SMCG_ACTIVE
            && mode_ff == smcg_pkg::MODE_PWR_SAVE && !ctrl_ff[smcg_pkg::CTRL_T2_ASYNC])
        begin
            async_regs_valid <= 1'b0;
        end
        else if (wr_pend_ff && wr_addr_ff == smcg_pkg::OFS_STATUS
            && hwdata[smcg_pkg::STAT_ASYNC_LOST])
        begin
            async_regs_valid <= 1'b1;
        end
    end

    // Scan port enable and its data-out driver.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scan_port_en <= 1'b0;
            tdo_o <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            scan_port_en <= scan_port_fuse_enable & !ctrl_ff[smcg_pkg::CTRL_SCAN_DIS];
            tdo_o <= tap_tdo_data;
            tdo_oe <= scan_port_en & tap_shifting;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY. Writes land in the data
    // phase; read data is sampled at the address phase so it comes from a flop.
    assign addr_ok = hsel && hready && htrans == smcg_pkg::HTRANS_NONSEQ
        && hsize == smcg_pkg::HSIZE_WORD;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_ff <= addr_ok && hwrite && haddr[31:8] == 24'h000000;
            wr_addr_ff <= haddr[7:0];
            hrdata <= 32'h00000000;
            if (addr_ok && !hwrite && haddr[31:8] == 24'h000000)
            begin
                case (haddr[7:0])
                    smcg_pkg::OFS_CTRL: hrdata <= {20'h00000, ctrl_ff};
                    smcg_pkg::OFS_STATUS: hrdata <= {21'h000000, mode_ff, 3'h0,
                        vref_cnt_ff == smcg_pkg::VREF_START_CYC, adc_extended_conv,
                        !async_regs_valid, state_ff == SMCG_WAKE, state_ff != SMCG_ACTIVE};
                    smcg_pkg::OFS_WAKE_DLY: hrdata <= {16'h0000, wake_dly_ff};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= smcg_pkg::CTRL_RESET;
            wake_dly_ff <= smcg_pkg::WAKE_DLY_RESET;
        end
        else if (wr_pend_ff)
        begin
            if (wr_addr_ff == smcg_pkg::OFS_CTRL)
            begin
                ctrl_ff <= hwdata[smcg_pkg::CTRL_WIDTH-1:0];
            end
            if (wr_addr_ff == smcg_pkg::OFS_WAKE_DLY && hwdata[15:0] != 16'h0000)
            begin
                wake_dly_ff <= hwdata[15:0];
            end
        end
    end

    // Checks.
    sequence wake_start_s;
        state_ff == SMCG_SLEEP && wake_hit;
    endsequence

    standby_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        wake_start_s and mode_ff[2:1] == 2'b11 |-> ##7 !core_halt && $past(core_halt))
        else $error("standby wake not six cycles");
    pdown_clocks_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == SMCG_SLEEP && mode_ff == smcg_pkg::MODE_PWR_DOWN && !debug_fuse_enable
        |-> clk_en == '0) else $error("power-down left a clock on");
    psave_asy_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == SMCG_SLEEP && mode_ff == smcg_pkg::MODE_PWR_SAVE
        |-> !clk_en.io && !clk_en.cpu && clk_en.asy == ctrl_ff[smcg_pkg::CTRL_T2_ASYNC])
        else $error("power-save gating wrong");
    reserved_code_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == SMCG_ACTIVE && sleep_exec && (ctrl_ff[2:1] == 2'b10
        || (ctrl_ff[2:1] == 2'b11 && !crystal_clock_sel)) |=> state_ff == SMCG_ACTIVE)
        else $error("illegal sleep code entered sleep");
    deep_wake_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == SMCG_SLEEP && mode_ff != smcg_pkg::MODE_IDLE && wake_hit
        |-> irq_sync_ff[2] || wake_src.two_wire_match || wake_src.timer2
        || wake_src.spm_ready || wake_src.adc_done
        || (irq_sync_ff[0] && ctrl_ff[smcg_pkg::CTRL_IRQ1_LVL])
        || (irq_sync_ff[1] && ctrl_ff[smcg_pkg::CTRL_IRQ2_LVL]))
        else $error("deep sleep woke on edge interrupt");
    vref_need_a: assert property (@(posedge core_clk) disable iff (rst)
        ##1 ana_en.vref == $past(brownout_fuse_enable || ctrl_ff[smcg_pkg::CTRL_ADC_EN]
        || (ctrl_ff[smcg_pkg::CTRL_CMP_EN] && ctrl_ff[smcg_pkg::CTRL_CMP_REF])))
        else $error("reference enable mismatch");
    tdo_float_a: assert property (@(posedge core_clk) disable iff (rst)
        tdo_oe |-> $past(tap_shifting) && $past(scan_port_fuse_enable, 2))
        else $error("data out driven while idle");
    adc_restart_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(ana_en.adc) |-> adc_extended_conv) else $error("restart not extended");
    cmp_auto_off_a: assert property (@(posedge core_clk) disable iff (rst)
        core_halt && !ana_en.input_buf |-> !ana_en.comparator)
        else $error("comparator left on in deep sleep");
    async_lost_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == SMCG_WAKE && nxt_state == SMCG_ACTIVE
        && mode_ff == smcg_pkg::MODE_PWR_SAVE && !ctrl_ff[smcg_pkg::CTRL_T2_ASYNC]
        |=> !async_regs_valid) else $error("async loss not flagged");

endmodule
